//--- shared/addr_core_pkg.sv
// Constants and types for the program and data memory addressing core
package addr_core_pkg;
    localparam int PC_W = 9;
    localparam int ROM_WORDS = 512;
    localparam int ROM_DATA_W = 8;
    localparam int PAGE_W = 6;
    localparam int PAGE_COUNT = 8;
    localparam int DIGIT_W = 4;
    localparam int REG_COUNT = 4;
    localparam int DIGITS_PER_REG = 8;
    localparam int REG_SEL_W = 2;
    localparam int DIG_SEL_W = 4;
    localparam int DIG_IDX_W = 3;
    localparam int PORT_W = 8;
    localparam int OSC_DIV = 4;
    localparam int OSC_DIV_W = 2;
    localparam logic [PC_W-1:0] PC_RESET = 9'h000;
    localparam logic [PC_W-1:0] PC_ONE = 9'h001;
    localparam logic [REG_SEL_W-1:0] DIRECT_REG = 2'h3;
    localparam logic [DIG_SEL_W-1:0] DIRECT_DIGIT = 4'hF;
    localparam logic [OSC_DIV_W-1:0] DIV_LAST = 2'h3;

    // Program counter actions, one per instruction cycle
    typedef enum logic [2:0] {
        PC_NEXT = 3'b000,
        PC_JUMP = 3'b001,
        PC_PAGE_JUMP = 3'b010,
        PC_CALL = 3'b011,
        PC_RETURN = 3'b100,
        PC_INDIRECT = 3'b101
    } pc_op_t;

    // Working memory digit operations
    typedef enum logic [2:0] {
        MEM_NONE = 3'b000,
        MEM_LOAD_ACC = 3'b001,
        MEM_STORE_ACC = 3'b010,
        MEM_EXCHANGE = 3'b011,
        MEM_TO_LATCH = 3'b100,
        MEM_FROM_PORT = 3'b101,
        MEM_EXCH_DIRECT = 3'b110
    } mem_op_t;
endpackage : addr_core_pkg

//--- core/cycle_divider.sv
// Divides the oscillator input into instruction cycle strobes
`timescale 1ns/1ps
module cycle_divider #(
    parameter int DIV = addr_core_pkg::OSC_DIV
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic run,
    output logic cycle_strobe
);
    // ----------------------------------------
    // Divider
    // ----------------------------------------
    localparam int LAST_I = DIV - 1;
    localparam logic [addr_core_pkg::OSC_DIV_W-1:0] LAST = LAST_I[addr_core_pkg::OSC_DIV_W-1:0];

    if (DIV != addr_core_pkg::OSC_DIV) begin : g_bad_div
        $error("Divider must be four");
    end

    logic [addr_core_pkg::OSC_DIV_W-1:0] cnt_q, cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (run) begin
            cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign cycle_strobe = run && (cnt_q == LAST);
endmodule : cycle_divider

//--- core/addr_core.sv
// Program counter, return stack and working memory addressing core
`timescale 1ns/1ps
// Behaviour
// - Program store is 512 bytes, viewed as 8 pages of 64 words.
// - A 9-bit program counter selects one program word.
// - Counter reloads every instruction cycle; sequential steps add one.
// - Two 9-bit return slots give two nesting levels.
// - Working memory is four registers of eight 4-bit digits.
// - Pointer: 2-bit register select, low 3 digit bits select digit.
// - Selected digit loads, stores, exchanges accumulator, to latch, from port.
// - Direct exchange uses register 3 digit 15 without the pointer.
// - One instruction cycle equals four oscillator input periods.
// - Halt stops oscillator clocking, freezing all internal state except the oscillator input sampling flops and the acc_load and latch_load pulses, which clear.
// - Bits are positive logic: set is 1, reset is 0.
// - Program counter counts across page boundaries.
// - Digit select top bit ignored, two values per physical digit.
module addr_core (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic oscillator_input,
    input wire logic halt_req,
    input wire logic [2:0] pc_op,
    input wire logic [addr_core_pkg::PC_W-1:0] jump_target,
    input wire logic [addr_core_pkg::PAGE_W-1:0] page_offset,
    input wire logic [addr_core_pkg::ROM_DATA_W-1:0] indirect_low,
    input wire logic [2:0] mem_op,
    input wire logic ptr_load,
    input wire logic [addr_core_pkg::REG_SEL_W-1:0] register_select_in,
    input wire logic [addr_core_pkg::DIG_SEL_W-1:0] digit_select_in,
    input wire logic [addr_core_pkg::DIGIT_W-1:0] acc_in,
    input wire logic [addr_core_pkg::PORT_W-1:0] port_in,
    output logic [addr_core_pkg::PC_W-1:0] program_counter,
    output logic [addr_core_pkg::PC_W-1:0] first_return_slot,
    output logic [addr_core_pkg::PC_W-1:0] second_return_slot,
    output logic [addr_core_pkg::REG_SEL_W-1:0] register_select,
    output logic [addr_core_pkg::DIG_SEL_W-1:0] digit_select,
    output logic [addr_core_pkg::DIGIT_W-1:0] mem_digit,
    output logic [addr_core_pkg::DIGIT_W-1:0] acc_out,
    output logic acc_load,
    output logic [addr_core_pkg::DIGIT_W-1:0] latch_out,
    output logic latch_load,
    output logic cycle_strobe,
    output logic halted
);
    localparam int PC_W = addr_core_pkg::PC_W;
    localparam int DW = addr_core_pkg::DIGIT_W;
    localparam int WORDS = addr_core_pkg::REG_COUNT * addr_core_pkg::DIGITS_PER_REG;
    localparam int IDX_W = addr_core_pkg::REG_SEL_W + addr_core_pkg::DIG_IDX_W;

    if (addr_core_pkg::ROM_WORDS != addr_core_pkg::PAGE_COUNT * (1 << addr_core_pkg::PAGE_W)) begin : g_bad_pages
        $error("Program store pages do not fill the store");
    end
    if (addr_core_pkg::ROM_WORDS != (1 << PC_W)) begin : g_bad_width
        $error("Counter width does not match store size");
    end

    // ----------------------------------------
    // Oscillator input sampling and halt
    // ----------------------------------------
    logic osc_s1_q, osc_s2_q, osc_s3_q;
    logic halted_q, halted_d;
    logic osc_rise;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= oscillator_input;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    always_comb begin
        halted_d = halted_q || (cycle_strobe && halt_req);
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            halted_q <= 1'b0;
        end else begin
            halted_q <= halted_d;
        end
    end

    assign osc_rise = osc_s2_q && !osc_s3_q && !halted_q;
    assign halted = halted_q;

    logic period_end;
    cycle_divider #(.DIV(addr_core_pkg::OSC_DIV)) u_div (
        .core_clk(core_clk),
        .nrst(nrst),
        .run(osc_rise),
        .cycle_strobe(period_end)
    );
    assign cycle_strobe = period_end;

    // ----------------------------------------
    // Program counter and return stack
    // ----------------------------------------
    logic [PC_W-1:0] pc_q, pc_d, ret1_q, ret1_d, ret2_q, ret2_d, pc_inc;

    function automatic logic [PC_W-1:0] next_seq(input logic [PC_W-1:0] pc);
        next_seq = pc + addr_core_pkg::PC_ONE;
    endfunction : next_seq

    assign pc_inc = next_seq(pc_q);

    always_comb begin
        pc_d = pc_q;
        ret1_d = ret1_q;
        ret2_d = ret2_q;
        if (cycle_strobe) begin
            unique case (addr_core_pkg::pc_op_t'(pc_op))
                addr_core_pkg::PC_NEXT: begin
                    pc_d = pc_inc;
                end
                addr_core_pkg::PC_JUMP: begin
                    pc_d = jump_target;
                end
                addr_core_pkg::PC_PAGE_JUMP: begin
                    pc_d = {pc_inc[PC_W-1:addr_core_pkg::PAGE_W], page_offset};
                end
                addr_core_pkg::PC_CALL: begin
                    ret2_d = ret1_q;
                    ret1_d = pc_inc;
                    pc_d = jump_target;
                end
                addr_core_pkg::PC_RETURN: begin
                    pc_d = ret1_q;
                    ret1_d = ret2_q;
                end
                addr_core_pkg::PC_INDIRECT: begin
                    pc_d = {pc_inc[PC_W-1], indirect_low};
                end
                default: begin
                    pc_d = pc_inc;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pc_q <= addr_core_pkg::PC_RESET;
            ret1_q <= addr_core_pkg::PC_RESET;
            ret2_q <= addr_core_pkg::PC_RESET;
        end else begin
            pc_q <= pc_d;
            ret1_q <= ret1_d;
            ret2_q <= ret2_d;
        end
    end

    assign program_counter = pc_q;
    assign first_return_slot = ret1_q;
    assign second_return_slot = ret2_q;

    // ----------------------------------------
    // Working memory and pointer
    // ----------------------------------------
    logic [DW-1:0] mem_q [WORDS];
    logic [DW-1:0] mem_d [WORDS];
    logic [addr_core_pkg::REG_SEL_W-1:0] reg_sel_q, reg_sel_d;
    logic [addr_core_pkg::DIG_SEL_W-1:0] dig_sel_q, dig_sel_d;
    logic [DW-1:0] acc_q, acc_d, latch_q, latch_d;
    logic acc_ld_q, acc_ld_d, latch_ld_q, latch_ld_d;
    logic [IDX_W-1:0] ptr_idx, direct_idx;

    function automatic logic [IDX_W-1:0] digit_index(
        input logic [addr_core_pkg::REG_SEL_W-1:0] r,
        input logic [addr_core_pkg::DIG_SEL_W-1:0] d
    );
        digit_index = {r, d[addr_core_pkg::DIG_IDX_W-1:0]};
    endfunction : digit_index

    assign ptr_idx = digit_index(reg_sel_q, dig_sel_q);
    assign direct_idx = digit_index(addr_core_pkg::DIRECT_REG, addr_core_pkg::DIRECT_DIGIT);

    always_comb begin
        mem_d = mem_q;
        reg_sel_d = reg_sel_q;
        dig_sel_d = dig_sel_q;
        acc_d = acc_q;
        latch_d = latch_q;
        acc_ld_d = 1'b0;
        latch_ld_d = 1'b0;
        if (cycle_strobe) begin
            unique case (addr_core_pkg::mem_op_t'(mem_op))
                addr_core_pkg::MEM_NONE: begin
                end
                addr_core_pkg::MEM_LOAD_ACC: begin
                    acc_d = mem_q[ptr_idx];
                    acc_ld_d = 1'b1;
                end
                addr_core_pkg::MEM_STORE_ACC: begin
                    mem_d[ptr_idx] = acc_in;
                end
                addr_core_pkg::MEM_EXCHANGE: begin
                    acc_d = mem_q[ptr_idx];
                    acc_ld_d = 1'b1;
                    mem_d[ptr_idx] = acc_in;
                end
                addr_core_pkg::MEM_TO_LATCH: begin
                    latch_d = mem_q[ptr_idx];
                    latch_ld_d = 1'b1;
                end
                addr_core_pkg::MEM_FROM_PORT: begin
                    mem_d[ptr_idx] = port_in[DW-1:0];
                end
                addr_core_pkg::MEM_EXCH_DIRECT: begin
                    acc_d = mem_q[direct_idx];
                    acc_ld_d = 1'b1;
                    mem_d[direct_idx] = acc_in;
                end
                default: begin
                end
            endcase
            if (ptr_load) begin
                reg_sel_d = register_select_in;
                dig_sel_d = digit_select_in;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reg_sel_q <= '0;
            dig_sel_q <= '0;
            acc_q <= '0;
            latch_q <= '0;
            acc_ld_q <= 1'b0;
            latch_ld_q <= 1'b0;
        end else begin
            reg_sel_q <= reg_sel_d;
            dig_sel_q <= dig_sel_d;
            acc_q <= acc_d;
            latch_q <= latch_d;
            acc_ld_q <= acc_ld_d;
            latch_ld_q <= latch_ld_d;
        end
    end

    // Working memory is not cleared by reset
    always_ff @(posedge core_clk) begin
        mem_q <= mem_d;
    end

    assign register_select = reg_sel_q;
    assign digit_select = dig_sel_q;
    assign mem_digit = mem_q[ptr_idx];
    assign acc_out = acc_q;
    assign acc_load = acc_ld_q;
    assign latch_out = latch_q;
    assign latch_load = latch_ld_q;
endmodule : addr_core

//--- verification/addr_core_checker.sv
// Assertion checker for the addressing core
`timescale 1ns/1ps
module addr_core_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic halt_req,
    input wire logic [2:0] pc_op,
    input wire logic [8:0] jump_target,
    input wire logic [5:0] page_offset,
    input wire logic [2:0] mem_op,
    input wire logic [8:0] program_counter,
    input wire logic [8:0] first_return_slot,
    input wire logic [8:0] second_return_slot,
    input wire logic [3:0] mem_digit,
    input wire logic [3:0] acc_out,
    input wire logic acc_load,
    input wire logic [3:0] latch_out,
    input wire logic latch_load,
    input wire logic cycle_strobe,
    input wire logic halted
);
    logic [8:0] pc_inc;
    logic [2:0] next_page;
    assign pc_inc = program_counter + 9'h001;
    assign next_page = pc_inc[8:6];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_go;
        cycle_strobe && !halt_req;
    endsequence
    sequence s_call;
        s_go ##0 (pc_op == 3'h3);
    endsequence
    a_pc_step: assert property (s_go ##0 (pc_op == 3'h0) |=> program_counter == $past(pc_inc))
        else $error("counter did not step");
    a_pc_hold: assert property (!cycle_strobe |=> $stable(program_counter) && $stable(first_return_slot)
        && $stable(second_return_slot)) else $error("state moved off strobe");
    a_jump_load: assert property (s_go ##0 (pc_op == 3'h1) |=> program_counter == $past(jump_target))
        else $error("jump target lost");
    a_page_jump: assert property (s_go ##0 (pc_op == 3'h2) |=>
        program_counter == {$past(next_page), $past(page_offset)}) else $error("page jump wrong");
    a_call_push: assert property (s_call |=> first_return_slot == $past(pc_inc) &&
        second_return_slot == $past(first_return_slot)) else $error("call push wrong");
    a_return_pop: assert property (s_go ##0 (pc_op == 3'h4) |=> program_counter == $past(first_return_slot)
        && first_return_slot == $past(second_return_slot)) else $error("return pop wrong");
    a_acc_take: assert property (s_go ##0 (mem_op == 3'h1 || mem_op == 3'h3) |=>
        acc_load && acc_out == $past(mem_digit)) else $error("accumulator not loaded");
    a_latch_copy: assert property (s_go ##0 (mem_op == 3'h4) |=> latch_load && latch_out == $past(mem_digit))
        else $error("latch not loaded");
    a_halt_freeze: assert property (halted |=> halted && !cycle_strobe)
        else $error("halt not held");
endmodule : addr_core_checker
bind addr_core addr_core_checker u_chk (
    .core_clk(core_clk),
    .nrst(nrst),
    .halt_req(halt_req),
    .pc_op(pc_op),
    .jump_target(jump_target),
    .page_offset(page_offset),
    .mem_op(mem_op),
    .program_counter(program_counter),
    .first_return_slot(first_return_slot),
    .second_return_slot(second_return_slot),
    .mem_digit(mem_digit),
    .acc_out(acc_out),
    .acc_load(acc_load),
    .latch_out(latch_out),
    .latch_load(latch_load),
    .cycle_strobe(cycle_strobe),
    .halted(halted)
);

//--- verification/testbench.sv
// Self-checking bench for the addressing core
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0, nrst = 1'b0, oscillator_input = 1'b0, halt_req = 1'b0, ptr_load = 1'b0, ld_next = 1'b0;
    logic [2:0] pc_op = 3'h0, mem_op = 3'h0;
    logic [8:0] jump_target = 9'h000, p;
    logic [5:0] page_offset = 6'h00;
    logic [7:0] indirect_low = 8'h00, port_in = 8'h00;
    logic [1:0] register_select_in = 2'h0, register_select;
    logic [3:0] digit_select_in = 4'h0, acc_in = 4'h0, digit_select, mem_digit, acc_out, latch_out;
    logic [8:0] program_counter, first_return_slot, second_return_slot;
    logic acc_load, latch_load, cycle_strobe, halted;
    int fails = 0, num_checks = 0, strobes = 0, ticks = 0;
    addr_core u_dut (
        .core_clk(core_clk),
        .nrst(nrst),
        .oscillator_input(oscillator_input),
        .halt_req(halt_req),
        .pc_op(pc_op),
        .jump_target(jump_target),
        .page_offset(page_offset),
        .indirect_low(indirect_low),
        .mem_op(mem_op),
        .ptr_load(ptr_load),
        .register_select_in(register_select_in),
        .digit_select_in(digit_select_in),
        .acc_in(acc_in),
        .port_in(port_in),
        .program_counter(program_counter),
        .first_return_slot(first_return_slot),
        .second_return_slot(second_return_slot),
        .register_select(register_select),
        .digit_select(digit_select),
        .mem_digit(mem_digit),
        .acc_out(acc_out),
        .acc_load(acc_load),
        .latch_out(latch_out),
        .latch_load(latch_load),
        .cycle_strobe(cycle_strobe),
        .halted(halted)
    );
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(negedge core_clk) if (cycle_strobe === 1'b1) strobes++;
    always @(posedge core_clk) begin
        ticks++;
        if (ticks == 5000) begin
            fails++;
            test_done;
        end
    end
    task check(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One instruction cycle of four oscillator periods
    task step(input logic [2:0] op, input logic [2:0] mo, input int ns);
        int n0;
        n0 = strobes;
        pc_op = op;
        mem_op = mo;
        ptr_load = ld_next;
        ld_next = 1'b0;
        repeat (4) begin
            oscillator_input = 1'b1;
            repeat (4) @(posedge core_clk);
            #1 oscillator_input = 1'b0;
            repeat (4) @(posedge core_clk);
            #1;
        end
        check(9'(strobes - n0), 9'(ns));
    endtask : step
    task jump(input logic [8:0] t);
        jump_target = t;
        step(3'h1, 3'h0, 1);
    endtask : jump
    task ptr(input logic [1:0] r, input logic [3:0] d);
        ld_next = 1'b1;
        register_select_in = r;
        digit_select_in = d;
        step(3'h0, 3'h0, 1);
    endtask : ptr
    task t_count;
        check(program_counter, 9'h000);
        check(9'(halted), 9'h000);
        jump(9'h03E);
        check(program_counter, 9'h03E);
        step(3'h0, 3'h0, 1);
        step(3'h0, 3'h0, 1);
        check(program_counter, 9'h040);
        jump(9'h1FF);
        step(3'h0, 3'h0, 1);
        check(program_counter, 9'h000);
        $display("test count done");
    endtask : t_count
    task t_stack;
        jump(9'h010);
        jump_target = 9'h100;
        step(3'h3, 3'h0, 1);
        check(first_return_slot, 9'h011);
        jump_target = 9'h050;
        step(3'h3, 3'h0, 1);
        check(first_return_slot, 9'h101);
        check(second_return_slot, 9'h011);
        step(3'h4, 3'h0, 1);
        check(program_counter, 9'h101);
        step(3'h4, 3'h0, 1);
        check(program_counter, 9'h011);
        jump(9'h07F);
        page_offset = 6'h05;
        step(3'h2, 3'h0, 1);
        check(program_counter, 9'h085);
        jump(9'h0FF);
        indirect_low = 8'h34;
        step(3'h5, 3'h0, 1);
        check(program_counter, 9'h134);
        $display("test stack done");
    endtask : t_stack
    task t_mem;
        ptr(2'h2, 4'h3);
        acc_in = 4'hA;
        step(3'h0, 3'h2, 1);
        ptr(2'h2, 4'hB);
        check(9'(mem_digit), 9'h00A);
        check(9'({register_select, digit_select}), 9'h02B);
        acc_in = 4'h5;
        step(3'h0, 3'h3, 1);
        check(9'(acc_out), 9'h00A);
        step(3'h0, 3'h4, 1);
        check(9'(latch_out), 9'h005);
        port_in = 8'h96;
        step(3'h0, 3'h5, 1);
        step(3'h0, 3'h1, 1);
        check(9'(acc_out), 9'h006);
        ptr(2'h3, 4'h7);
        acc_in = 4'h7;
        step(3'h0, 3'h2, 1);
        ptr(2'h2, 4'h3);
        acc_in = 4'hC;
        step(3'h0, 3'h6, 1);
        check(9'(acc_out), 9'h007);
        check(9'(mem_digit), 9'h006);
        ptr(2'h3, 4'hF);
        check(9'(mem_digit), 9'h00C);
        $display("test memory done");
    endtask : t_mem
    task t_halt;
        halt_req = 1'b1;
        step(3'h0, 3'h0, 1);
        halt_req = 1'b0;
        p = program_counter;
        check(9'(halted), 9'h001);
        step(3'h0, 3'h0, 0);
        check(program_counter, p);
        nrst = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 nrst = 1'b1;
        check(9'(halted), 9'h000);
        check(9'(acc_out), 9'h000);
        step(3'h0, 3'h0, 1);
        check(program_counter, 9'h001);
        $display("test halt done");
    endtask : t_halt
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (10) @(posedge core_clk);
        #1 nrst = 1'b1;
        t_count;
        t_stack;
        t_mem;
        t_halt;
        test_done;
    end
endmodule : testbench
